// >>> src/ssv_pkg.sv
package ssv_pkg;
  // serial link timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_NORMAL = 2400;
  localparam int unsigned BAUD_TURBO = 9600;
  localparam int unsigned TURBO_MUL = 4;
  localparam int unsigned BAUD_DIV_DEF = CLK_HZ / BAUD_NORMAL;
  localparam int unsigned DIV_W = 17;

  // nonvolatile map
  localparam int unsigned NVM_BYTES = 48;
  localparam logic [5:0] ADDR_MODE = 6'h00;
  localparam logic [5:0] ADDR_SPAN_LO = 6'h02;
  localparam logic [5:0] ADDR_SPAN_HI = 6'h03;
  localparam logic [5:0] ADDR_ZERO_LO = 6'h04;
  localparam logic [5:0] ADDR_ZERO_HI = 6'h05;
  localparam logic [5:0] ADDR_FRONT = 6'h06;
  localparam logic [5:0] ADDR_ERR_LO = 6'h07;
  localparam logic [5:0] ADDR_ERR_HI = 6'h08;
  localparam logic [5:0] ADDR_TRIG_LO = 6'h09;
  localparam logic [5:0] ADDR_OUT_LO = 6'h0a;
  localparam logic [5:0] ADDR_TRIG_HI = 6'h0b;
  localparam logic [5:0] ADDR_OUT_HI = 6'h0c;
  localparam logic [5:0] ADDR_SOURCE = 6'h0d;
  localparam logic [5:0] ADDR_FILTER = 6'h19;
  localparam logic [5:0] ADDR_SUM_BAL = 6'h2f;
  localparam logic [5:0] ADDR_LAST = 6'h2f;
  localparam logic [5:0] ADDR_SOFT_RST = 6'h3f;
  localparam logic [7:0] SUM_GOOD = 8'hff;
  localparam logic [7:0] RESET_ACK = 8'hbc;
  localparam logic [7:0] NVM_RESET = 8'h00;

  // operating mode byte fields
  localparam int unsigned MB_VOLT = 0;
  localparam int unsigned MB_CURR = 1;
  localparam int unsigned MB_TURBO = 2;
  localparam int unsigned MB_ANALOG = 3;
  localparam int unsigned MB_FUNC_EN = 4;
  localparam int unsigned MB_STEER = 5;
  localparam int unsigned MB_INT_TEMP = 6;
  localparam int unsigned MB_CHK = 7;

  // front-end byte fields
  localparam int unsigned FB_ZERO = 0;
  localparam int unsigned FB_IN_GAIN = 2;
  localparam int unsigned FB_VOUT_AMP = 4;
  localparam int unsigned FB_TGAIN = 5;
  localparam int unsigned FB_INVERT = 7;

  // command byte
  localparam int unsigned CMD_WRITE = 7;

  // alarm / steering source codes
  localparam logic [2:0] SRC_IN_AMP = 3'h0;
  localparam logic [2:0] SRC_SPAN_AMP = 3'h1;
  localparam logic [2:0] SRC_TEMP_AMP = 3'h2;
  localparam logic [2:0] SRC_VSTAGE = 3'h3;
  localparam logic [2:0] SRC_PIN_A = 3'h4;
  localparam logic [2:0] SRC_PIN_B = 3'h5;

  typedef enum logic [1:0] {
    SSV_LOAD,
    SSV_CMD,
    SSV_DATA,
    SSV_SEND
  } ssv_state_e;

  typedef struct packed {
    logic [1:0] rx_sync;
    logic rx_act;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_vld;
    logic [7:0] rx_data;
    logic tx_act;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic tx;
  } ssv_uart_s;
endpackage : ssv_pkg

// >>> src/ssv_uart.sv
`timescale 1ns/1ps
module ssv_uart
  import ssv_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [DIV_W-1:0] div_i,
  input wire logic rx_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_start_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic tx_o,
  output logic tx_busy_o
);
  ssv_uart_s r, n;

  always_comb begin
    n = r;
    n.rx_vld = 1'b0;
    n.rx_sync = {r.rx_sync[0], rx_i};
    // receive 8N1, lsb first, sampled mid-bit
    if (!r.rx_act) begin
      if (!r.rx_sync[1]) begin
        n.rx_act = 1'b1;
        n.rx_cnt = {1'b0, div_i[DIV_W-1:1]};
        n.rx_bit = 4'h0;
      end
    end else if (r.rx_cnt != '0) begin
      n.rx_cnt = r.rx_cnt - 1'b1;
    end else begin
      n.rx_cnt = div_i - 1'b1;
      n.rx_bit = r.rx_bit + 4'h1;
      if (r.rx_bit == 4'h0) begin
        // glitch on idle line is not a start bit
        if (r.rx_sync[1]) n.rx_act = 1'b0;
      end else if (r.rx_bit < 4'h9) begin
        n.rx_sh = {r.rx_sync[1], r.rx_sh[7:1]};
      end else begin
        n.rx_act = 1'b0;
        if (r.rx_sync[1]) begin
          n.rx_vld = 1'b1;
          n.rx_data = r.rx_sh;
        end
      end
    end
    // transmit
    if (!r.tx_act) begin
      n.tx = 1'b1;
      if (tx_start_i) begin
        n.tx_act = 1'b1;
        n.tx_sh = {1'b1, tx_data_i, 1'b0};
        n.tx_cnt = div_i - 1'b1;
        n.tx_bit = 4'h0;
        n.tx = 1'b0;
      end
    end else if (r.tx_cnt != '0) begin
      n.tx_cnt = r.tx_cnt - 1'b1;
    end else begin
      n.tx_cnt = div_i - 1'b1;
      n.tx_bit = r.tx_bit + 4'h1;
      n.tx_sh = {1'b1, r.tx_sh[9:1]};
      n.tx = r.tx_sh[1];
      if (r.tx_bit == 4'h9) begin
        n.tx_act = 1'b0;
        n.tx = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.rx_sync <= 2'h3;
      r.tx <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign rx_data_o = r.rx_data;
  assign rx_valid_o = r.rx_vld;
  assign tx_o = r.tx;
  assign tx_busy_o = r.tx_act;
endmodule : ssv_uart

// >>> src/ssv_supervisor.sv
`timescale 1ns/1ps
module ssv_supervisor
  import ssv_pkg::*;
#(
  parameter int unsigned BAUD_DIV = BAUD_DIV_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_rx_i,
  output logic link_tx_o,
  input wire logic [9:0] input_amp_out_i,
  input wire logic [9:0] span_amp_out_i,
  input wire logic [9:0] temp_amp_out_i,
  input wire logic [9:0] voltage_stage_out_i,
  input wire logic [9:0] proc_code_i,
  input wire logic steer_pin_a_i,
  input wire logic steer_pin_b_i,
  output logic steer_pin_a_o,
  output logic steer_pin_a_oe_o,
  output logic steer_pin_b_o,
  output logic steer_pin_b_oe_o,
  output logic [9:0] dac_code_o,
  output logic dac_force_o,
  output logic volt_out_en_o,
  output logic curr_out_en_o,
  output logic turbo_o,
  output logic analog_path_o,
  output logic digital_path_o,
  output logic int_temp_sel_o,
  output logic ext_temp_sel_o,
  output logic swap_inputs_o,
  output logic [1:0] temp_amp_gain_o,
  output logic [1:0] coarse_zero_trim_o,
  output logic vout_amp_sel_o,
  output logic [1:0] input_gain_o,
  output logic [9:0] fine_span_trim_o,
  output logic [9:0] fine_zero_trim_o,
  output logic [3:0] temp_filter_o,
  output logic chk_fail_o,
  output logic ready_o
);
  typedef struct packed {
    ssv_state_e st;
    logic [NVM_BYTES-1:0][7:0] nvm;
    logic [5:0] addr;
    logic [5:0] idx;
    logic [7:0] sum;
    logic ack_due;
    logic tx_go;
    logic [7:0] tx_byte;
    logic volt;
    logic curr;
    logic turbo;
    logic ana;
    logic dig;
    logic alarm_en;
    logic steer_en;
    logic int_t;
    logic ext_t;
    logic chk_en;
    logic chk_fail;
    logic swap;
    logic [1:0] tgain;
    logic [1:0] czero;
    logic vamp;
    logic [1:0] igain;
    logic [9:0] span;
    logic [9:0] zero;
    logic [9:0] err;
    logic [7:0] trig_lo;
    logic [7:0] out_lo;
    logic [7:0] trig_hi;
    logic [7:0] out_hi;
    logic [2:0] src;
    logic [3:0] filt;
    logic [1:0] pa_sync;
    logic [1:0] pb_sync;
    logic [9:0] dac;
    logic force_o;
    logic [1:0] steer;
  } ssv_main_s;

  localparam logic [DIV_W-1:0] DIV_NORM = DIV_W'(BAUD_DIV);
  localparam logic [DIV_W-1:0] DIV_FAST = DIV_W'(BAUD_DIV / TURBO_MUL);

  ssv_main_s r, n;
  logic [7:0] rx_data;
  logic rx_valid;
  logic tx_busy;
  logic tx_line;
  logic [DIV_W-1:0] div;

  // turbo only takes effect with the settings loaded at reset
  assign div = r.turbo ? DIV_FAST : DIV_NORM;

  ssv_uart u_uart (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .div_i(div),
    .rx_i(link_rx_i),
    .tx_data_i(r.tx_byte),
    .tx_start_i(r.tx_go),
    .rx_data_o(rx_data),
    .rx_valid_o(rx_valid),
    .tx_o(tx_line),
    .tx_busy_o(tx_busy)
  );

  always_comb begin
    logic [7:0] byte_v;
    logic [7:0] total;
    logic [7:0] mode;
    logic [7:0] fe;
    logic [9:0] src10;
    logic [7:0] src8;
    byte_v = '0;
    total = '0;
    mode = '0;
    fe = '0;
    src10 = '0;
    src8 = '0;
    n = r;
    n.tx_go = 1'b0;
    n.pa_sync = {r.pa_sync[0], steer_pin_a_i};
    n.pb_sync = {r.pb_sync[0], steer_pin_b_i};

    case (r.st)
      SSV_LOAD: begin
        byte_v = r.nvm[r.idx];
        total = r.sum + byte_v;
        n.sum = total;
        n.idx = r.idx + 6'h01;
        if (r.idx == ADDR_LAST) begin
          mode = r.nvm[ADDR_MODE];
          fe = r.nvm[ADDR_FRONT];
          // working copy refreshed only here
          n.volt = mode[MB_VOLT];
          n.curr = mode[MB_CURR];
          n.turbo = mode[MB_TURBO];
          n.ana = mode[MB_ANALOG];
          n.dig = ~mode[MB_ANALOG];
          n.steer_en = mode[MB_FUNC_EN] & mode[MB_STEER];
          n.alarm_en = mode[MB_FUNC_EN] & ~mode[MB_STEER];
          n.int_t = mode[MB_INT_TEMP];
          n.ext_t = ~mode[MB_INT_TEMP];
          n.chk_en = mode[MB_CHK];
          // a passing sum clears an earlier failure
          n.chk_fail = mode[MB_CHK] & (total != SUM_GOOD);
          n.swap = fe[FB_INVERT];
          n.czero = fe[FB_ZERO +: 2];
          n.tgain = fe[FB_TGAIN +: 2];
          n.igain = fe[FB_IN_GAIN +: 2];
          n.vamp = fe[FB_VOUT_AMP];
          n.span = {r.nvm[ADDR_SPAN_HI][1:0], r.nvm[ADDR_SPAN_LO]};
          n.zero = {r.nvm[ADDR_ZERO_HI][1:0], r.nvm[ADDR_ZERO_LO]};
          n.err = {r.nvm[ADDR_ERR_HI][1:0], r.nvm[ADDR_ERR_LO]};
          n.trig_lo = r.nvm[ADDR_TRIG_LO];
          n.out_lo = r.nvm[ADDR_OUT_LO];
          n.trig_hi = r.nvm[ADDR_TRIG_HI];
          n.out_hi = r.nvm[ADDR_OUT_HI];
          n.src = r.nvm[ADDR_SOURCE][2:0];
          // upper nibble ignored; illegal codes saturate at heaviest
          n.filt = (r.nvm[ADDR_FILTER][3:0] > 4'h6) ? 4'h6 :
                   r.nvm[ADDR_FILTER][3:0];
          if (r.ack_due) begin
            n.st = SSV_SEND;
            n.tx_byte = RESET_ACK;
          end else begin
            n.st = SSV_CMD;
          end
        end
      end
      SSV_CMD: begin
        if (rx_valid) begin
          n.addr = rx_data[5:0];
          if (rx_data[CMD_WRITE]) begin
            n.st = SSV_DATA;
          end else if (rx_data[5:0] == ADDR_SOFT_RST) begin
            // no data byte for this address, only the ack
            n.st = SSV_LOAD;
            n.idx = '0;
            n.sum = '0;
            n.ack_due = 1'b1;
          end else begin
            n.st = SSV_SEND;
            n.tx_byte = (rx_data[5:0] <= ADDR_LAST) ?
                        r.nvm[rx_data[5:0]] : 8'h00;
          end
        end
      end
      SSV_DATA: begin
        if (rx_valid) begin
          n.st = SSV_CMD;
          // takes effect only after the next soft reset; a hardware reset clears the map
          if (r.addr <= ADDR_LAST) n.nvm[r.addr] = rx_data;
        end
      end
      SSV_SEND: begin
        if (!tx_busy && !r.tx_go) begin
          n.tx_go = 1'b1;
          n.ack_due = 1'b0;
          n.st = SSV_CMD;
        end
      end
      default: n.st = SSV_CMD;
    endcase

    case (r.src)
      SRC_IN_AMP: src10 = input_amp_out_i;
      SRC_SPAN_AMP: src10 = span_amp_out_i;
      SRC_TEMP_AMP: src10 = temp_amp_out_i;
      SRC_VSTAGE: src10 = voltage_stage_out_i;
      SRC_PIN_A: src10 = {10{r.pa_sync[1]}};
      SRC_PIN_B: src10 = {10{r.pb_sync[1]}};
      default: src10 = '0;
    endcase
    src8 = src10[9:2];

    // checksum error outranks alarm clamping
    n.force_o = 1'b0;
    n.dac = proc_code_i;
    if (r.chk_fail) begin
      n.dac = r.err;
      n.force_o = 1'b1;
    end else if (r.alarm_en && src8 > r.trig_hi) begin
      n.dac = {r.out_hi, 2'b00};
      n.force_o = 1'b1;
    end else if (r.alarm_en && src8 < r.trig_lo) begin
      n.dac = {r.out_lo, 2'b00};
      n.force_o = 1'b1;
    end

    // levels share the alarm bytes; no hysteresis
    if (!r.steer_en) begin
      n.steer = 2'b00;
    end else if (src8 >= r.trig_hi) begin
      n.steer = 2'b11;
    end else if (src8 >= r.out_lo) begin
      n.steer = 2'b10;
    end else if (src8 >= r.trig_lo) begin
      n.steer = 2'b01;
    end else begin
      n.steer = 2'b00;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.st <= SSV_LOAD;
    end else begin
      r <= n;
    end
  end

  // pins are outputs only while steering is on
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_tx_o <= 1'b1;
      steer_pin_a_oe_o <= 1'b0;
      steer_pin_b_oe_o <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      link_tx_o <= tx_line;
      steer_pin_a_oe_o <= n.steer_en;
      steer_pin_b_oe_o <= n.steer_en;
      ready_o <= (n.st != SSV_LOAD);
    end
  end

  assign steer_pin_a_o = r.steer[1];
  assign steer_pin_b_o = r.steer[0];
  assign dac_code_o = r.dac;
  assign dac_force_o = r.force_o;
  assign volt_out_en_o = r.volt;
  assign curr_out_en_o = r.curr;
  assign turbo_o = r.turbo;
  assign analog_path_o = r.ana;
  assign digital_path_o = r.dig;
  assign int_temp_sel_o = r.int_t;
  assign ext_temp_sel_o = r.ext_t;
  assign swap_inputs_o = r.swap;
  assign temp_amp_gain_o = r.tgain;
  assign coarse_zero_trim_o = r.czero;
  assign vout_amp_sel_o = r.vamp;
  assign input_gain_o = r.igain;
  assign fine_span_trim_o = r.span;
  assign fine_zero_trim_o = r.zero;
  assign temp_filter_o = r.filt;
  assign chk_fail_o = r.chk_fail;
endmodule : ssv_supervisor

// >>> tb/ssv_supervisor_props.sv
`timescale 1ns/1ps
module ssv_supervisor_props
  import ssv_pkg::*;
#(
  parameter int unsigned BAUD_DIV = BAUD_DIV_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_tx_o,
  input wire logic [9:0] dac_code_o,
  input wire logic dac_force_o,
  input wire logic steer_pin_a_oe_o,
  input wire logic analog_path_o,
  input wire logic digital_path_o,
  input wire logic int_temp_sel_o,
  input wire logic ext_temp_sel_o,
  input wire logic turbo_o,
  input wire logic [3:0] temp_filter_o,
  input wire logic chk_fail_o,
  input wire logic ready_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_walk_len: assert property (
    $fell(ready_o) |-> !ready_o [*8] ##[30:50] ready_o)
    else $error("reload walk length out of range");
  a_link_quiet: assert property (!ready_o |-> link_tx_o)
    else $error("link active during reload");
  a_path_excl: assert property (
    ready_o |-> analog_path_o != digital_path_o)
    else $error("signal path selects not exclusive");
  a_temp_excl: assert property (
    ready_o |-> int_temp_sel_o != ext_temp_sel_o)
    else $error("temperature sensor selects not exclusive");
  a_filter_max: assert property (temp_filter_o <= 4'h6)
    else $error("filter setting above six");
  // the converter code lags the flag by one cycle
  a_fail_force: assert property (
    ready_o && chk_fail_o && $past(chk_fail_o) |=>
    dac_force_o && $stable(dac_code_o))
    else $error("error code not held on converter");
  a_clamp_code: assert property (
    dac_force_o && !chk_fail_o && !$past(chk_fail_o) |->
    dac_code_o[1:0] == 2'b00)
    else $error("alarm value not in top bits");
  a_steer_excl: assert property (
    steer_pin_a_oe_o && $past(steer_pin_a_oe_o) && !chk_fail_o &&
    !$past(chk_fail_o) |-> !dac_force_o)
    else $error("alarm clamp during steering");
  a_cfg_hold: assert property (
    ready_o && $past(ready_o) |->
    $stable({turbo_o, analog_path_o, chk_fail_o, temp_filter_o}))
    else $error("settings changed without reload");

  c_fail: cover property (ready_o && chk_fail_o);
  c_clamp: cover property (dac_force_o && !chk_fail_o);
  c_steer: cover property (ready_o && steer_pin_a_oe_o);
endmodule : ssv_supervisor_props

// >>> tb/ssv_host.sv
`timescale 1ns/1ps
module ssv_host #(
  parameter int DIV = 16
) (
  input wire logic clk_i,
  input wire logic dev_tx_i,
  output logic host_tx_o,
  output logic [7:0] rx_byte_o,
  output logic rx_stb_o
);
  int bit_t = DIV;
  initial begin
    host_tx_o = 1'b1;
    rx_stb_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  // 8n1, lsb first; line left high between frames
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      host_tx_o <= f[i];
      repeat (bit_t - 1) @(negedge clk_i);
    end
  endtask : send
  // mid-bit sampling: a device bit rate off by much shifts the bits
  always begin
    @(negedge dev_tx_i);
    repeat (bit_t / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_t) @(posedge clk_i);
      rx_byte_o[i] <= dev_tx_i;
    end
    repeat (bit_t) @(posedge clk_i);
    rx_stb_o <= dev_tx_i;
    @(posedge clk_i);
    rx_stb_o <= 1'b0;
  end
endmodule : ssv_host

// >>> tb/ssv_supervisor_tb.sv
`timescale 1ns/1ps
bind ssv_supervisor ssv_supervisor_props #(.BAUD_DIV(BAUD_DIV)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .link_tx_o(link_tx_o),
  .dac_code_o(dac_code_o), .dac_force_o(dac_force_o),
  .steer_pin_a_oe_o(steer_pin_a_oe_o), .analog_path_o(analog_path_o),
  .digital_path_o(digital_path_o), .int_temp_sel_o(int_temp_sel_o),
  .ext_temp_sel_o(ext_temp_sel_o), .turbo_o(turbo_o),
  .temp_filter_o(temp_filter_o), .chk_fail_o(chk_fail_o),
  .ready_o(ready_o));

module ssv_supervisor_tb;
  import ssv_pkg::*;
  localparam int DIV = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pa = 1'b0, pb = 1'b0, h2d, d2h, got, sa, sb, sa_oe, sb_oe;
  logic frc, dig, ext, fail, rdy;
  logic [7:0] m, fe, rb, e;
  logic [9:0] pc = 10'h000, dac, spn, zro;
  logic [9:0] src [4] = '{default: 10'h000};
  logic [3:0] flt;
  logic [31:0] lf = 32'h5d3d;
  logic [7:0] img [48] = '{default: 8'h00};
  logic [7:0] q [$];
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  logic [5:0] cfg_a [13] = '{6'h00, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
    6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h19};
  logic [7:0] cfg_d [13] = '{8'h8a, 8'ha5, 8'h02, 8'h5a, 8'h01, 8'hb5,
    8'hc7, 8'h03, 8'h40, 8'h80, 8'hc0, 8'hee, 8'h05};

  always #5 clk = ~clk;

  ssv_supervisor #(.BAUD_DIV(DIV)) dut (.clk_i(clk), .rst_n_i(rst_n),
    .link_rx_i(h2d), .link_tx_o(d2h), .input_amp_out_i(src[0]),
    .span_amp_out_i(src[1]), .temp_amp_out_i(src[2]),
    .voltage_stage_out_i(src[3]), .proc_code_i(pc), .steer_pin_a_i(pa),
    .steer_pin_b_i(pb), .steer_pin_a_o(sa), .steer_pin_a_oe_o(sa_oe),
    .steer_pin_b_o(sb), .steer_pin_b_oe_o(sb_oe), .dac_code_o(dac),
    .dac_force_o(frc), .volt_out_en_o(m[0]), .curr_out_en_o(m[1]),
    .turbo_o(m[2]), .analog_path_o(m[3]), .digital_path_o(dig),
    .int_temp_sel_o(m[6]), .ext_temp_sel_o(ext), .swap_inputs_o(fe[7]),
    .temp_amp_gain_o(fe[6:5]), .coarse_zero_trim_o(fe[1:0]),
    .vout_amp_sel_o(fe[4]), .input_gain_o(fe[3:2]),
    .fine_span_trim_o(spn), .fine_zero_trim_o(zro), .temp_filter_o(flt),
    .chk_fail_o(fail), .ready_o(rdy));

  ssv_host #(.DIV(DIV)) u_host (.clk_i(clk), .dev_tx_i(d2h),
    .host_tx_o(h2d), .rx_byte_o(rb), .rx_stb_o(got));

  function automatic logic [9:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[9:0];
  endfunction : rnd

  task automatic chk(input string nm, input logic [11:0] ex, gt);
    checks++;
    if (gt !== ex) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, ex, gt);
    end
  endtask : chk

  task automatic give_verdict();
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.send({2'b10, a});
    u_host.send(d);
    if (a < 6'h30) img[a] = d;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] ex);
    q.push_back(ex);
    u_host.send({2'b00, a});
    // the acknowledge already comes at the freshly loaded rate
    if (a == ADDR_SOFT_RST) begin
      u_host.bit_t = img[0][MB_TURBO] ? DIV / 4 : DIV;
    end
    wait (q.size() == 0);
  endtask : rd

  task automatic reload(input logic [7:0] bad);
    logic [7:0] s;
    logic bs;
    s = 8'h00;
    for (int i = 0; i < 47; i++) s += img[i];
    wr(ADDR_SUM_BAL, (SUM_GOOD - s) ^ bad);
    rd(ADDR_SOFT_RST, RESET_ACK);
    @(negedge clk);
    bs = img[0][MB_CHK] && bad != 8'h00;
    chk("mode", img[0] & 8'h4f, m & 8'h4f);
    chk("digital", !img[0][MB_ANALOG], dig);
    chk("ext_temp", !img[0][MB_INT_TEMP], ext);
    chk("front", img[6], fe);
    chk("span", {img[3][1:0], img[2]}, spn);
    chk("zero", {img[5][1:0], img[4]}, zro);
    chk("filter", img[25][3:0], flt);
    chk("fail", bs, fail);
    if (bs) chk("err", {1'b1, img[8][1:0], img[7]}, {frc, dac});
  endtask : reload

  task automatic sweep();
    logic [9:0] v, ex;
    logic [7:0] t;
    logic [2:0] c;
    logic [1:0] lv;
    logic cl;
    for (int k = 0; k < 24; k++) begin
      foreach (src[j]) src[j] = rnd();
      pc = rnd();
      v = rnd();
      pa = v[9];
      pb = v[8];
      // pins pass a two-stage synchroniser before the source mux
      repeat (6) @(negedge clk);
      c = img[ADDR_SOURCE][2:0];
      v = c < 3'h4 ? src[c[1:0]] : {10{c == 3'h4 ? pa : pb}};
      t = v[9:2];
      if (img[0][MB_STEER]) begin
        lv = t >= img[11] ? 2'h3 : t >= img[10] ? 2'h2 : {1'b0, t >= img[9]};
        chk("steer", {3'h3, lv}, {frc, sa_oe, sb_oe, sa, sb});
      end else begin
        cl = t > img[ADDR_TRIG_HI] || t < img[ADDR_TRIG_LO];
        ex = t > img[ADDR_TRIG_HI] ? {img[ADDR_OUT_HI], 2'b00} : pc;
        if (t < img[ADDR_TRIG_LO]) ex = {img[ADDR_OUT_LO], 2'b00};
        chk("alarm", {cl, sa_oe, ex}, {frc, 1'b0, dac});
      end
    end
  endtask : sweep

  always @(posedge clk) begin
    cyc++;
    if (got) begin
      e = q.size() != 0 ? q.pop_front() : 8'hxx;
      checks++;
      if (rb !== e) begin
        n_fail++;
        $display("mismatch reply exp %h got %h", e, rb);
      end
    end
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    wait (rdy);
    @(negedge clk);
    rd(ADDR_MODE, NVM_RESET);
    wr(6'h32, 8'h77);
    rd(6'h32, 8'h00);
    foreach (cfg_a[i]) wr(cfg_a[i], cfg_d[i]);
    chk("front_early", 12'h000, fe);
    rd(ADDR_FRONT, 8'hb5);
    reload(8'h01);
    reload(8'h00);
    chk("force", 12'h000, frc);
    wr(ADDR_MODE, 8'hd1);
    for (int s = 0; s < 6; s++) begin
      wr(ADDR_SOURCE, s[7:0]);
      reload(8'h00);
      sweep();
    end
    wr(ADDR_MODE, 8'hb1);
    wr(ADDR_SOURCE, 8'h01);
    reload(8'h00);
    sweep();
    wr(ADDR_MODE, 8'h87);
    reload(8'h00);
    rd(ADDR_SOURCE, 8'h01);
    give_verdict();
  end
endmodule : ssv_supervisor_tb
